// ==== bench/scfg_prog_model.sv ====
// Programmer model: programming entry and external writes
`timescale 1ns/1ns
module scfg_prog_model (
    // Clock, reset and bench commands
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_enter,
    input wire logic i_lv,
    input wire logic i_lvp_en,
    // Toward the device
    output logic o_prog_mode,
    output logic o_prog_lv_entry,
    output logic o_ext_wr_req
);
    // Low-voltage entry only while the device allows it, else high voltage
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prog_mode <= 1'h0;
            o_prog_lv_entry <= 1'h0;
        end else begin
            o_prog_mode <= i_enter;
            o_prog_lv_entry <= i_enter & i_lv & i_lvp_en;
        end
    end
    // Writes are offered whenever programming mode is held
    assign o_ext_wr_req = o_prog_mode;
endmodule

// ==== bench/scfg_top_chk.sv ====
// Port checker for the configuration decoder
`timescale 1ns/1ns
`include "scfg_defs.svh"
module scfg_top_chk (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Inputs watched
    input wire logic i_rd,
    input wire logic [15:0] i_addr,
    input wire logic i_dev_reset,
    input wire logic i_stack_fault,
    input wire logic i_self_wr_req,
    input wire logic i_ext_wr_req,
    // Outputs watched
    input wire logic [15:0] o_rdata,
    input wire logic o_self_wr_allow,
    input wire logic o_self_wr_blocked,
    input wire logic o_ext_wr_allow,
    input wire logic o_debug_en,
    input wire logic o_prog_pins_gpio,
    input wire logic o_stack_reset_req,
    input wire logic o_stack_slot0_wr_inhibit,
    input wire logic o_pinmap_locked_flag,
    input wire logic o_pinmap_lock_frozen,
    input wire logic o_brownout_low_trip,
    input wire logic o_ultra_lowpower_brownout,
    input wire logic [1:0] o_watchdog_en_field,
    input wire logic o_watchdog_always_on,
    input wire logic o_powerup_timer,
    input wire logic o_ext_reset_input,
    input wire logic o_lowvolt_prog_en
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence fault_s;
        o_stack_slot0_wr_inhibit && i_stack_fault;
    endsequence
    sequence frozen_s;
        o_pinmap_lock_frozen && o_pinmap_locked_flag;
    endsequence
    stack_reset_a: assert property (fault_s |=> o_stack_reset_req)
        else $error("stack reset missing");
    stack_cause_a: assert property ($rose(o_stack_reset_req) |->
        $past(o_stack_slot0_wr_inhibit)) else $error("stack reset without fault");
    debug_pins_a: assert property (o_debug_en != o_prog_pins_gpio)
        else $error("debug and gpio agree");
    wdt_code_a: assert property (o_watchdog_always_on == (o_watchdog_en_field == 2'h3))
        else $error("watchdog decode wrong");
    lvp_reset_a: assert property (o_lowvolt_prog_en |-> o_ext_reset_input)
        else $error("reset input not forced");
    ext_write_a: assert property (o_ext_wr_allow == i_ext_wr_req)
        else $error("external write gated");
    self_write_a: assert property (i_self_wr_req ? (o_self_wr_allow != o_self_wr_blocked)
        : !(o_self_wr_allow || o_self_wr_blocked)) else $error("self write verdict wrong");
    read_width_a: assert property ($past(i_rd) |-> o_rdata[15:14] == 2'h0 &&
        ($past(i_addr) != `SCFG_ADDR_SUP_WORD || o_rdata[10] && o_rdata[8] && o_rdata[4]) &&
        ($past(i_addr) != `SCFG_ADDR_MEM_WORD || &o_rdata[12:2]))
        else $error("read upper bits set");
    static_decode_a: assert property (!$past(i_dev_reset) |-> $stable({o_prog_pins_gpio,
        o_brownout_low_trip, o_ultra_lowpower_brownout, o_watchdog_en_field,
        o_powerup_timer, o_lowvolt_prog_en})) else $error("decode moved");
    frozen_hold_a: assert property (frozen_s |=> frozen_s)
        else $error("frozen lock released");
    frozen_set_a: assert property ($rose(o_pinmap_lock_frozen) |->
        $rose(o_pinmap_locked_flag)) else $error("froze without set");
endmodule
bind scfg_top scfg_top_chk u_scfg_top_chk (.i_clock, .i_rst_n, .i_rd, .i_addr, .i_dev_reset,
    .i_stack_fault, .i_self_wr_req, .i_ext_wr_req, .o_rdata, .o_self_wr_allow,
    .o_self_wr_blocked, .o_ext_wr_allow, .o_debug_en, .o_prog_pins_gpio, .o_stack_reset_req,
    .o_stack_slot0_wr_inhibit, .o_pinmap_locked_flag, .o_pinmap_lock_frozen,
    .o_brownout_low_trip, .o_ultra_lowpower_brownout, .o_watchdog_en_field,
    .o_watchdog_always_on, .o_powerup_timer, .o_ext_reset_input, .o_lowvolt_prog_en);

// ==== bench/test_scfg_top.sv ====
// Self-checking bench for the configuration decoder
`timescale 1ns/1ns
`include "scfg_defs.svh"
module test_scfg_top;
    logic i_clock = 1'h0;
    logic i_rst_n = 1'h0;
    logic [15:0] i_addr = 16'h0000;
    logic [15:0] i_wdata = 16'h0000;
    logic [13:0] i_self_wr_addr = 14'h0000;
    logic i_wr = 1'h0, i_rd = 1'h0, i_dev_reset = 1'h0, i_sleep = 1'h0;
    logic i_stack_fault = 1'h0, i_self_wr_req = 1'h0, enter = 1'h0, lv = 1'h0;
    logic i_prog_mode, i_prog_lv_entry, i_ext_wr_req;
    logic [15:0] o_rdata;
    logic [1:0] o_watchdog_en_field;
    logic o_self_wr_allow, o_self_wr_blocked, o_ext_wr_allow, o_debug_en, o_prog_pins_gpio;
    logic o_stack_reset_req, o_stack_slot0_wr_inhibit, o_pinmap_locked_flag;
    logic o_pinmap_lock_frozen, o_brownout_active, o_brownout_low_trip;
    logic o_ultra_lowpower_brownout, o_watchdog_always_on, o_powerup_timer;
    logic o_ext_reset_input, o_lowvolt_prog_en;
    int n_errors = 0;
    int n_tests = 0;
    localparam logic [13:0] WA [5] = '{14'h01FF, 14'h0200, 14'h1FFF, 14'h2000, 14'h3FFF};

    scfg_top u_scfg_top (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_dev_reset, .i_prog_mode, .i_prog_lv_entry, .i_sleep, .i_stack_fault,
        .i_self_wr_req, .i_self_wr_addr, .i_ext_wr_req, .o_self_wr_allow, .o_self_wr_blocked,
        .o_ext_wr_allow, .o_debug_en, .o_prog_pins_gpio, .o_stack_reset_req,
        .o_stack_slot0_wr_inhibit, .o_pinmap_locked_flag, .o_pinmap_lock_frozen,
        .o_brownout_active, .o_brownout_low_trip, .o_ultra_lowpower_brownout,
        .o_watchdog_en_field, .o_watchdog_always_on, .o_powerup_timer, .o_ext_reset_input,
        .o_lowvolt_prog_en);
    scfg_prog_model u_scfg_prog_model (.i_clock, .i_rst_n, .i_enter(enter), .i_lv(lv),
        .i_lvp_en(o_lowvolt_prog_en), .o_prog_mode(i_prog_mode),
        .o_prog_lv_entry(i_prog_lv_entry), .o_ext_wr_req(i_ext_wr_req));

    always #4 i_clock = ~i_clock;

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_wr <= 1'h1;
        i_rd <= 1'h0;
        i_addr <= a;
        i_wdata <= d;
    endtask
    task automatic idle;
        @(posedge i_clock);
        i_wr <= 1'h0;
        i_rd <= 1'h0;
    endtask
    task automatic rdchk(input string n, input logic [15:0] a, input logic [15:0] e);
        @(posedge i_clock);
        i_wr <= 1'h0;
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'h0;
        #1 chk(n, o_rdata, e);
    endtask
    // Decoded controls only move on a device reset, so every word change ends here
    task automatic reload;
        idle();
        i_dev_reset <= 1'h1;
        @(posedge i_clock);
        i_dev_reset <= 1'h0;
        @(posedge i_clock);
        #1;
    endtask
    task automatic wcfg(input logic [15:0] a, input logic [15:0] d, input logic low);
        @(posedge i_clock);
        enter <= 1'h1;
        lv <= low;
        repeat (2) @(posedge i_clock);
        wr(a, d);
        idle();
        enter <= 1'h0;
        reload();
    endtask
    task automatic t_blank;
        chk("debug_en", o_debug_en, 0);
        chk("wdt_on", o_watchdog_always_on, 1);
        chk("powerup_timer", o_powerup_timer, 0);
        chk("ulp", o_ultra_lowpower_brownout, 0);
        chk("low_trip", o_brownout_low_trip, 1);
        chk("ext_rst", o_ext_reset_input, 1);
        rdchk("mem", `SCFG_ADDR_MEM_WORD, 16'h3FFF);
        rdchk("unmapped", 16'h0100, 16'h0000);
        wr(`SCFG_ADDR_SUP_WORD, 16'h0000);
        rdchk("sup_locked", `SCFG_ADDR_SUP_WORD, 16'h3FFF);
        $display("test blank done");
    endtask
    task automatic t_decode;
        wcfg(`SCFG_ADDR_SUP_WORD, 16'h0000, 0);
        wcfg(`SCFG_ADDR_MEM_WORD, 16'h0000, 0);
        rdchk("sup", `SCFG_ADDR_SUP_WORD, 16'h0510);
        rdchk("mem", `SCFG_ADDR_MEM_WORD, 16'h1FFC);
        chk("debug_en", o_debug_en, 1);
        chk("low_trip", o_brownout_low_trip, 0);
        chk("ulp", o_ultra_lowpower_brownout, 1);
        chk("wdt", o_watchdog_en_field, 0);
        chk("powerup_timer", o_powerup_timer, 1);
        chk("ext_rst", o_ext_reset_input, 0);
        rdchk("status", `SCFG_ADDR_STATUS, 16'h00A1);
        wcfg(`SCFG_ADDR_MEM_WORD, 16'h2000, 0);
        chk("lvp", o_lowvolt_prog_en, 1);
        chk("ext_rst_lvp", o_ext_reset_input, 1);
        $display("test decode done");
    endtask
    task automatic t_bor;
        for (int m = 0; m < 4; m++) begin
            wcfg(`SCFG_ADDR_SUP_WORD, {8'h3F, 2'(m), 6'h3F}, 0);
            for (int k = 0; k < 4; k++) begin
                wr(`SCFG_ADDR_CTRL, 16'(k % 2));
                idle();
                i_sleep <= 1'(k / 2);
                @(posedge i_clock);
                #1 chk("bor", o_brownout_active,
                    (m == 3) || (m == 2 && k < 2) || (m == 1 && k % 2 == 1));
            end
        end
        i_sleep <= 1'h0;
        $display("test brownout done");
    endtask
    task automatic t_wrt;
        for (int c = 0; c < 4; c++) begin
            wcfg(`SCFG_ADDR_MEM_WORD, 16'h3FFC | 16'(c), 0);
            enter <= 1'h1;
            for (int j = 0; j < 5; j++) begin
                @(posedge i_clock);
                i_self_wr_req <= 1'h1;
                i_self_wr_addr <= WA[j];
                #1 chk("blocked", o_self_wr_blocked,
                    c == 0 || (c == 1 && j < 3) || (c == 2 && j == 0));
                chk("ext_allow", o_ext_wr_allow, 1);
            end
            i_self_wr_req <= 1'h0;
            enter <= 1'h0;
        end
        $display("test write protect done");
    endtask
    task automatic t_lvp;
        wcfg(`SCFG_ADDR_MEM_WORD, 16'h0003, 1);
        rdchk("lv_keep", `SCFG_ADDR_MEM_WORD, 16'h3FFF);
        wcfg(`SCFG_ADDR_MEM_WORD, 16'h0003, 0);
        rdchk("hv_clear", `SCFG_ADDR_MEM_WORD, 16'h1FFF);
        wcfg(`SCFG_ADDR_ERASE, `SCFG_ERASE_KEY, 0);
        rdchk("erased", `SCFG_ADDR_MEM_WORD, 16'h3FFF);
        $display("test low voltage done");
    endtask
    task automatic t_stack(input logic en);
        wcfg(`SCFG_ADDR_SUP_WORD, en ? 16'h3FFF : 16'h2FFF, 0);
        @(posedge i_clock);
        i_stack_fault <= 1'h1;
        #1 chk("inhibit", o_stack_slot0_wr_inhibit, en);
        @(posedge i_clock);
        i_stack_fault <= 1'h0;
        #1 chk("stack_req", o_stack_reset_req, en);
        $display("test stack done");
    endtask
    task automatic lock(input logic [15:0] d, input logic [1:0] e);
        wr(`SCFG_ADDR_UNLOCK, 16'h0055);
        wr(`SCFG_ADDR_UNLOCK, 16'h00AA);
        wr(`SCFG_ADDR_LOCK, d);
        idle();
        #1 chk("lock", {o_pinmap_lock_frozen, o_pinmap_locked_flag}, e);
    endtask
    task automatic t_lock;
        wcfg(`SCFG_ADDR_SUP_WORD, 16'h37FF, 0);
        lock(16'h0001, 2'h1);
        lock(16'h0000, 2'h0);
        wr(`SCFG_ADDR_LOCK, 16'h0001);
        idle();
        #1 chk("no_window", o_pinmap_locked_flag, 0);
        wcfg(`SCFG_ADDR_SUP_WORD, 16'h3FFF, 0);
        lock(16'h0001, 2'h3);
        lock(16'h0000, 2'h3);
        rdchk("lock_rd", `SCFG_ADDR_LOCK, 16'h0003);
        $display("test lock done");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge i_clock);
        i_rst_n <= 1'h1;
        @(posedge i_clock);
        #1 t_blank();
        t_decode();
        t_bor();
        t_wrt();
        t_lvp();
        t_stack(1'h1);
        t_stack(1'h0);
        t_lock();
        // A second power-on mid-run must blank the words and drop the lock
        @(posedge i_clock);
        i_rst_n <= 1'h0;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'h1;
        rdchk("sup_por", `SCFG_ADDR_SUP_WORD, 16'h3FFF);
        chk("frozen_por", o_pinmap_lock_frozen, 0);
        tally_and_finish();
    end
endmodule

// ==== pkg/scfg_defs.svh ====
// Offsets, field positions, reset values and codes for the configuration decoder
`ifndef SCFG_DEFS_SVH
`define SCFG_DEFS_SVH

// Register addresses
`define SCFG_ADDR_SUP_WORD 16'h8008
`define SCFG_ADDR_MEM_WORD 16'h8009
`define SCFG_ADDR_CTRL 16'h8010
`define SCFG_ADDR_LOCK 16'h8011
`define SCFG_ADDR_UNLOCK 16'h8012
`define SCFG_ADDR_STATUS 16'h8013
`define SCFG_ADDR_ERASE 16'h8014

// Widths
`define SCFG_WORD_W 14
`define SCFG_DATA_W 16
`define SCFG_ADDR_W 16

// Reset and blank values
`define SCFG_BLANK_WORD 14'h3FFF
`define SCFG_SUP_UNIMPL_MASK 14'h0510
`define SCFG_MEM_UNIMPL_MASK 14'h1FFC
`define SCFG_RDATA_RESET 16'h0000
`define SCFG_SOFT_BOR_RESET 1'h0
`define SCFG_LOCKED_RESET 1'h0

// Supervisor word fields
`define SCFG_SUP_DEBUG_BIT 13
`define SCFG_SUP_STACK_BIT 12
`define SCFG_SUP_ONEWAY_BIT 11
`define SCFG_SUP_BROWNOUT_THRESHOLD_SEL_BIT 9
`define SCFG_SUP_BORMODE_HI 7
`define SCFG_SUP_BORMODE_LO 6
`define SCFG_SUP_LPBOR_BIT 5
`define SCFG_SUP_WDT_HI 3
`define SCFG_SUP_WDT_LO 2
`define SCFG_SUP_POWERUP_TIMER_BIT 1
`define SCFG_SUP_EXTRST_BIT 0

// Memory word fields
`define SCFG_MEM_LVP_BIT 13
`define SCFG_MEM_WRT_HI 1
`define SCFG_MEM_WRT_LO 0

// Control and lock register fields
`define SCFG_CTRL_SOFT_BOR_BIT 0
`define SCFG_LOCK_FLAG_BIT 0
`define SCFG_LOCK_FROZEN_BIT 1

// Watchdog code for always on
`define SCFG_WDT_ALWAYS_ON 2'h3

// Self-write protection upper bounds
`define SCFG_WP_BOOT_TOP 14'h01FF
`define SCFG_WP_HALF_TOP 14'h1FFF
`define SCFG_WP_ALL_TOP 14'h3FFF

// Keys
`define SCFG_UNLOCK_KEY1 8'h55
`define SCFG_UNLOCK_KEY2 8'hAA
`define SCFG_ERASE_KEY 16'hE5A5

`endif

// ==== pkg/scfg_lock_if.sv ====
// Carrier between the decoder and the pin-mapping lock controller
`timescale 1ns/1ns
interface scfg_lock_if;
    logic unlock_wr;
    logic lock_wr;
    logic [7:0] wdata;
    logic one_way;
    logic locked;
    logic frozen;

    modport ctrl (
        output unlock_wr,
        output lock_wr,
        output wdata,
        output one_way,
        input locked,
        input frozen
    );

    modport lock (
        input unlock_wr,
        input lock_wr,
        input wdata,
        input one_way,
        output locked,
        output frozen
    );
endinterface

// ==== pkg/scfg_pkg.sv ====
// Types for the configuration decoder
package scfg_pkg;

    typedef enum logic [1:0] {
        SCFG_BOR_OFF = 2'h0,
        SCFG_BOR_SOFT = 2'h1,
        SCFG_BOR_RUN = 2'h2,
        SCFG_BOR_ON = 2'h3
    } scfg_bor_mode_t;

    typedef enum logic [1:0] {
        SCFG_WP_ALL = 2'h0,
        SCFG_WP_HALF = 2'h1,
        SCFG_WP_BOOT = 2'h2,
        SCFG_WP_OFF = 2'h3
    } scfg_wp_mode_t;

    // Gray along idle, first key, open
    typedef enum logic [1:0] {
        SCFG_LK_IDLE = 2'h0,
        SCFG_LK_KEY1 = 2'h1,
        SCFG_LK_OPEN = 2'h3
    } scfg_lock_st_t;

    typedef struct packed {
        scfg_lock_st_t st;
        logic locked;
        logic frozen;
    } scfg_lock_state_t;

    typedef struct packed {
        logic [13:0] sup_word;
        logic [13:0] mem_word;
        logic [13:0] sup_live;
        logic [13:0] mem_live;
        logic loaded;
        logic soft_bor;
        logic stack_rst;
        logic [15:0] rdata;
    } scfg_state_t;

endpackage

// ==== rtl/scfg_pinmap_lock.sv ====
// Pin-mapping locked flag with unlock sequence and one-way policy
`timescale 1ns/1ns
`include "scfg_defs.svh"
module scfg_pinmap_lock
    import scfg_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Link to the decoder
    scfg_lock_if.lock lk
);

    scfg_lock_state_t state;
    scfg_lock_state_t next_state;

    always_comb begin
        next_state = state;
        case (state.st)
            SCFG_LK_IDLE: begin
                if (lk.unlock_wr && lk.wdata == `SCFG_UNLOCK_KEY1) begin
                    next_state.st = SCFG_LK_KEY1;
                end
            end
            SCFG_LK_KEY1: begin
                // Any other write to the unlock or lock register between the keys aborts the sequence
                if (lk.unlock_wr && lk.wdata == `SCFG_UNLOCK_KEY2) begin
                    next_state.st = SCFG_LK_OPEN;
                end else if (lk.unlock_wr || lk.lock_wr) begin
                    next_state.st = SCFG_LK_IDLE;
                end
            end
            SCFG_LK_OPEN: begin
                // Window lasts one cycle only
                next_state.st = SCFG_LK_IDLE;
                if (lk.lock_wr && !state.frozen) begin
                    next_state.locked = lk.wdata[`SCFG_LOCK_FLAG_BIT];
                    if (lk.one_way && lk.wdata[`SCFG_LOCK_FLAG_BIT]) begin
                        next_state.frozen = 1'h1;
                    end
                end
            end
            default: begin
                next_state.st = SCFG_LK_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state.st <= SCFG_LK_IDLE;
            state.locked <= `SCFG_LOCKED_RESET;
            state.frozen <= 1'h0;
        end else begin
            state <= next_state;
        end
    end

    assign lk.locked = state.locked;
    assign lk.frozen = state.frozen;

endmodule

// ==== rtl/scfg_top.sv ====
// Supervisor and memory configuration word store and decoder
//
// Operation
// - Debug bit 1 frees programming pins
// - Stack-fault reset follows its enable bit
// - One-way policy allows single clear-set cycle
// - Otherwise lock flag toggles via unlock sequence
// - Threshold bit picks low or high trip
// - Brown-out mode field decodes four modes
// - Low-power brown-out enable is active low
// - Watchdog code 11 means always on
// - Power-up timer enable is active low
// - Low-voltage programming forces external reset input
// - Low-voltage enable ignores external reset bit
// - Refuse clearing low-voltage bit in LV mode
// - Self-write protection range decode blocks writes
// - External programming writes never blocked
// - Unimplemented configuration bits read as one
// - Stack-fault reset spares stack location zero
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`include "scfg_defs.svh"
module scfg_top
    import scfg_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Register port
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Device status
    input wire logic i_dev_reset,
    input wire logic i_prog_mode,
    input wire logic i_prog_lv_entry,
    input wire logic i_sleep,
    input wire logic i_stack_fault,
    // Self-write and external write requests
    input wire logic i_self_wr_req,
    input wire logic [13:0] i_self_wr_addr,
    input wire logic i_ext_wr_req,
    output logic o_self_wr_allow,
    output logic o_self_wr_blocked,
    output logic o_ext_wr_allow,
    // Debug and pins
    output logic o_debug_en,
    output logic o_prog_pins_gpio,
    // Stack fault handling
    output logic o_stack_reset_req,
    output logic o_stack_slot0_wr_inhibit,
    // Pin mapping lock
    output logic o_pinmap_locked_flag,
    output logic o_pinmap_lock_frozen,
    // Brown-out supervisors
    output logic o_brownout_active,
    output logic o_brownout_low_trip,
    output logic o_ultra_lowpower_brownout,
    // Watchdog and power-up timer
    output logic [1:0] o_watchdog_en_field,
    output logic o_watchdog_always_on,
    output logic o_powerup_timer,
    // Reset pin and programming entry
    output logic o_ext_reset_input,
    output logic o_lowvolt_prog_en
);

    scfg_state_t state;
    scfg_state_t next_state;
    scfg_lock_if lk_if ();

    logic wr_sup;
    logic wr_mem;
    logic wr_ctrl;
    logic wr_lock;
    logic wr_unlock;
    logic wr_erase;
    logic [13:0] wr_word;
    logic [13:0] mem_wr_val;
    logic stack_fault_reset_en;
    logic pinmap_one_way_lock;
    logic brownout_threshold_sel;
    scfg_bor_mode_t brownout_mode;
    logic lowpower_brownout_en_n;
    logic powerup_timer_en_n;
    logic ext_reset_pin_en;
    logic lowvolt_prog_en;
    scfg_wp_mode_t self_write_protect;
    logic [13:0] wp_top;
    logic wp_all_open;
    logic wp_hit;
    logic [13:0] status_word;

    // Address decode, writes
    assign wr_sup = i_wr && (i_addr == `SCFG_ADDR_SUP_WORD);
    assign wr_mem = i_wr && (i_addr == `SCFG_ADDR_MEM_WORD);
    assign wr_ctrl = i_wr && (i_addr == `SCFG_ADDR_CTRL);
    assign wr_lock = i_wr && (i_addr == `SCFG_ADDR_LOCK);
    assign wr_unlock = i_wr && (i_addr == `SCFG_ADDR_UNLOCK);
    assign wr_erase = i_wr && (i_addr == `SCFG_ADDR_ERASE);

    // Unimplemented positions are stored as one so reads never show zero there
    assign wr_word = i_wdata[13:0];

    always_comb begin
        mem_wr_val = wr_word | `SCFG_MEM_UNIMPL_MASK;
        // A low-voltage session must not disable its own entry method
        if (i_prog_lv_entry && !wr_word[`SCFG_MEM_LVP_BIT]) begin
            mem_wr_val[`SCFG_MEM_LVP_BIT] = state.mem_word[`SCFG_MEM_LVP_BIT];
        end
    end

    // Field extraction from the copies latched at reset
    assign stack_fault_reset_en = state.sup_live[`SCFG_SUP_STACK_BIT];
    assign pinmap_one_way_lock = state.sup_live[`SCFG_SUP_ONEWAY_BIT];
    assign brownout_threshold_sel = state.sup_live[`SCFG_SUP_BROWNOUT_THRESHOLD_SEL_BIT];
    assign brownout_mode = scfg_bor_mode_t'(
        state.sup_live[`SCFG_SUP_BORMODE_HI:`SCFG_SUP_BORMODE_LO]);
    assign lowpower_brownout_en_n = state.sup_live[`SCFG_SUP_LPBOR_BIT];
    assign powerup_timer_en_n = state.sup_live[`SCFG_SUP_POWERUP_TIMER_BIT];
    assign ext_reset_pin_en = state.sup_live[`SCFG_SUP_EXTRST_BIT];
    assign lowvolt_prog_en = state.mem_live[`SCFG_MEM_LVP_BIT];
    assign self_write_protect = scfg_wp_mode_t'(
        state.mem_live[`SCFG_MEM_WRT_HI:`SCFG_MEM_WRT_LO]);

    // Self-write protection range
    always_comb begin
        wp_top = `SCFG_WP_ALL_TOP;
        wp_all_open = 1'h0;
        case (self_write_protect)
            SCFG_WP_OFF: begin
                wp_all_open = 1'h1;
            end
            SCFG_WP_BOOT: begin
                wp_top = `SCFG_WP_BOOT_TOP;
            end
            SCFG_WP_HALF: begin
                wp_top = `SCFG_WP_HALF_TOP;
            end
            SCFG_WP_ALL: begin
                wp_top = `SCFG_WP_ALL_TOP;
            end
            default: begin
                wp_top = `SCFG_WP_ALL_TOP;
            end
        endcase
    end

    assign wp_hit = !wp_all_open && (i_self_wr_addr <= wp_top);
    assign o_self_wr_allow = i_self_wr_req && !wp_hit;
    assign o_self_wr_blocked = i_self_wr_req && wp_hit;
    // Protection never looks at the programming path
    assign o_ext_wr_allow = i_ext_wr_req;

    // Brown-out enable decode
    always_comb begin
        case (brownout_mode)
            SCFG_BOR_ON: begin
                o_brownout_active = 1'h1;
            end
            SCFG_BOR_RUN: begin
                o_brownout_active = !i_sleep;
            end
            SCFG_BOR_SOFT: begin
                o_brownout_active = state.soft_bor;
            end
            SCFG_BOR_OFF: begin
                o_brownout_active = 1'h0;
            end
            default: begin
                o_brownout_active = 1'h0;
            end
        endcase
    end

    // Threshold applies whenever the detector runs
    assign o_brownout_low_trip = brownout_threshold_sel;
    assign o_ultra_lowpower_brownout = !lowpower_brownout_en_n;

    // Watchdog and power-up timer
    assign o_watchdog_en_field = state.sup_live[`SCFG_SUP_WDT_HI:`SCFG_SUP_WDT_LO];
    assign o_watchdog_always_on = (o_watchdog_en_field == `SCFG_WDT_ALWAYS_ON);
    assign o_powerup_timer = !powerup_timer_en_n;

    // Reset pin function and programming entry
    assign o_ext_reset_input = lowvolt_prog_en || ext_reset_pin_en;
    assign o_lowvolt_prog_en = lowvolt_prog_en;

    // Debug ownership of the programming pins
    assign o_debug_en = !state.sup_live[`SCFG_SUP_DEBUG_BIT];
    assign o_prog_pins_gpio = state.sup_live[`SCFG_SUP_DEBUG_BIT];

    // Stack fault: the inhibit is combinational so the wrap write never lands
    assign o_stack_reset_req = state.stack_rst;
    assign o_stack_slot0_wr_inhibit = stack_fault_reset_en && i_stack_fault;

    // Lock controller link
    assign lk_if.unlock_wr = wr_unlock;
    assign lk_if.lock_wr = wr_lock;
    assign lk_if.wdata = i_wdata[7:0];
    assign lk_if.one_way = pinmap_one_way_lock;
    assign o_pinmap_locked_flag = lk_if.locked;
    assign o_pinmap_lock_frozen = lk_if.frozen;

    scfg_pinmap_lock u_lock (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .lk(lk_if.lock)
    );

    // Decoded status snapshot for software
    assign status_word = {
        4'h0,
        o_ext_reset_input,
        o_lowvolt_prog_en,
        o_powerup_timer,
        o_watchdog_always_on,
        o_ultra_lowpower_brownout,
        o_brownout_low_trip,
        o_brownout_active,
        stack_fault_reset_en,
        o_prog_pins_gpio,
        o_debug_en
    };

    always_comb begin
        next_state = state;
        next_state.rdata = `SCFG_RDATA_RESET;

        // Only the programmer may alter the nonvolatile words
        if (i_prog_mode) begin
            if (wr_sup) begin
                next_state.sup_word = wr_word | `SCFG_SUP_UNIMPL_MASK;
            end
            if (wr_mem) begin
                next_state.mem_word = mem_wr_val;
            end
            // Bulk erase leaves every bit at one
            if (wr_erase && i_wdata == `SCFG_ERASE_KEY) begin
                next_state.sup_word = `SCFG_BLANK_WORD;
                next_state.mem_word = `SCFG_BLANK_WORD;
            end
        end

        if (wr_ctrl) begin
            next_state.soft_bor = i_wdata[`SCFG_CTRL_SOFT_BOR_BIT];
        end

        // Decode is captured once after reset and held; later programming
        // only takes effect at the next device reset
        if (!state.loaded || i_dev_reset) begin
            next_state.sup_live = state.sup_word;
            next_state.mem_live = state.mem_word;
            next_state.loaded = 1'h1;
        end

        next_state.stack_rst = stack_fault_reset_en && i_stack_fault;

        if (i_rd) begin
            case (i_addr)
                `SCFG_ADDR_SUP_WORD: begin
                    next_state.rdata = {2'h0, state.sup_word};
                end
                `SCFG_ADDR_MEM_WORD: begin
                    next_state.rdata = {2'h0, state.mem_word};
                end
                `SCFG_ADDR_CTRL: begin
                    next_state.rdata = {15'h0000, state.soft_bor};
                end
                `SCFG_ADDR_LOCK: begin
                    next_state.rdata = {14'h0000, lk_if.frozen, lk_if.locked};
                end
                `SCFG_ADDR_STATUS: begin
                    next_state.rdata = {2'h0, status_word};
                end
                default: begin
                    next_state.rdata = `SCFG_RDATA_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state.sup_word <= `SCFG_BLANK_WORD;
            state.mem_word <= `SCFG_BLANK_WORD;
            state.sup_live <= `SCFG_BLANK_WORD;
            state.mem_live <= `SCFG_BLANK_WORD;
            state.loaded <= 1'h0;
            state.soft_bor <= `SCFG_SOFT_BOR_RESET;
            state.stack_rst <= 1'h0;
            state.rdata <= `SCFG_RDATA_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign o_rdata = state.rdata;

endmodule
